// ==== hdl/addr_mux_if.sv ====
// Carrier between the sequencer and the address pin multiplexer
`timescale 1ns/1ps
interface addr_mux_if;
    import sdram_pkg::*;

    logic [ADDR_W-1:0] addr;
    port_size_type port_size;
    logic [COL_LINES_W-1:0] col_lines;
    logic col_phase;
    logic [ADDR_W-1:0] pins;

    modport ctrl (
        output addr,
        output port_size,
        output col_lines,
        output col_phase,
        input pins
    );

    modport mux (
        input addr,
        input port_size,
        input col_lines,
        input col_phase,
        output pins
    );
endinterface : addr_mux_if

// ==== hdl/address_pin_mux.sv ====
// Row and column multiplexing of internal address bits onto address pins
`timescale 1ns/1ps
module address_pin_mux
    import sdram_pkg::*;
(
    addr_mux_if.mux bus_if
);

    wire [ADDR_W-1:0] pin_vec;

    // Source bit for a pin in the column phase, or -1 to keep the row bit
    function automatic int col_source(input int pin, input port_size_type size,
                                      input logic [COL_LINES_W-1:0] lines);
        int src;
        src = -1;
        case (size)
            PORT_8: begin
                if (pin >= PIN_LOW && pin <= PIN_BASE_TOP) begin
                    src = PIN_BASE_TOP - pin;
                end else if (pin >= PIN_ODD_LO && pin <= PIN_8_EXTRA_HI && (pin % 2) == 1 &&
                             lines >= 4'(LINES_MIN_8 + (pin - PIN_ODD_LO) / 2)) begin
                    src = pin - 1;
                end
            end
            PORT_16: begin
                if (pin >= PIN_LOW && pin <= PIN_16_TOP) begin
                    src = PIN_BASE_TOP - pin;
                end else if (pin >= PIN_EXTRA_LO && pin <= PIN_16_EXTRA_HI &&
                             lines >= 4'(LINES_MIN_WIDE + (pin - PIN_EXTRA_LO) / 2)) begin
                    src = pin - 1;
                end
            end
            default: begin
                if (pin >= PIN_LOW && pin <= PIN_32_TOP) begin
                    src = PIN_BASE_TOP - pin;
                end else if (pin == PIN_32_HI) begin
                    src = COL_32_HI;
                end else if (pin == PIN_EXTRA_LO && lines == LINES_EIGHT) begin
                    src = pin - 1;
                end else if (pin >= PIN_ODD_LO && pin <= PIN_8_EXTRA_HI && (pin % 2) == 1 &&
                             lines >= 4'(LINES_MIN_WIDE + (pin - PIN_ODD_LO) / 2)) begin
                    src = pin - 1;
                end
            end
        endcase
        return src;
    endfunction : col_source

    // One selector per pin; the choice depends on port size and column lines
    genvar p;
    generate
        for (p = 0; p < ADDR_W; p++) begin : g_pin
            assign pin_vec[p] = (bus_if.col_phase && col_source(p, bus_if.port_size, bus_if.col_lines) >= 0) ?
                bus_if.addr[5'(col_source(p, bus_if.port_size, bus_if.col_lines))] :
                bus_if.addr[p];
        end
    endgenerate

    assign bus_if.pins = pin_vec;

endmodule : address_pin_mux

// ==== hdl/sdram_command_address_mux.sv ====
// SDRAM command sequencer driving strobes, selects, byte masks and clock
`timescale 1ns/1ps
module sdram_command_address_mux
    import sdram_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Access request from the controller core
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic req_block_in,
    input wire logic [LANES-1:0] req_lane_en_in,
    output logic req_ready_out,
    output logic done_out,
    // Static configuration
    input wire port_size_type port_size_in,
    input wire logic [COL_LINES_W-1:0] col_lines_in,
    input wire logic cke_command_mode_in,
    input wire logic cke_command_bit_in,
    input wire logic power_down_in,
    // SDRAM pins
    output logic [ADDR_W-1:0] addr_pins_out,
    output logic row_strobe_n_out,
    output logic col_strobe_n_out,
    output logic write_strobe_n_out,
    output logic [BLOCKS-1:0] block_select_n_out,
    output logic mem_clock_enable_out,
    output logic [LANES-1:0] byte_strobe_out,
    output logic memory_clock_out
);

    // ****************************************************************
    // Local state
    // ****************************************************************
    logic [3:0] div_q;
    logic mem_clk_q;
    logic fall_tick;
    seq_state_type state_q;
    seq_state_type state_d;
    logic [3:0] wait_q;
    logic [ADDR_W-1:0] addr_q;
    logic write_q;
    logic block_q;
    logic [LANES-1:0] lane_en_q;
    logic cmd_bit_q;
    logic ready_q;
    logic done_q;
    logic [ADDR_W-1:0] pins_q;
    logic ras_n_q;
    logic cas_n_q;
    logic we_n_q;
    logic [BLOCKS-1:0] cs_n_q;
    logic cke_q;
    logic [LANES-1:0] dqm_q;
    logic accept;
    logic pend_q;

    addr_mux_if mux_bus ();

    // ****************************************************************
    // Forwarded memory clock
    // ****************************************************************

    // Divider counts half periods of the memory clock
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            div_q <= 4'h0;
        end else if (div_q == HALF_LAST) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // Clock toggles from a flip-flop so the pin has no glitches
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mem_clk_q <= 1'b0;
        end else if (div_q == HALF_LAST) begin
            mem_clk_q <= ~mem_clk_q;
        end
    end

    // Pins change on the falling memory edge, half a period before the SDRAM samples
    assign fall_tick = mem_clk_q && (div_q == HALF_LAST);

    // ****************************************************************
    // Request capture
    // ****************************************************************

    // A request is only taken while idle and not powered down
    assign accept = req_valid_in && ready_q && !power_down_in;

    // Request fields are held for the whole access
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            addr_q <= ADDR_RESET;
            write_q <= 1'b0;
            block_q <= 1'b0;
            lane_en_q <= '0;
            cmd_bit_q <= 1'b0;
        end else if (accept) begin
            addr_q <= req_addr_in;
            write_q <= req_write_in;
            block_q <= req_block_in;
            lane_en_q <= req_lane_en_in;
            cmd_bit_q <= cke_command_bit_in;
        end
    end

    // Accepted request waits here for the next falling memory edge to start it.
    // Ready alone cannot carry it: ready is recomputed every cycle, and a phantom
    // access would follow a power-down release if a low ready meant "pending"
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pend_q <= 1'b0;
        end else if (accept) begin
            pend_q <= 1'b1;
        end else if (state_q == ST_IDLE && state_d == ST_ROW) begin
            pend_q <= 1'b0;
        end
    end

    // Ready drops on acceptance and returns when the sequencer is back to idle.
    // It stays low while a request waits, so a second one cannot overwrite it
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ready_q <= 1'b0;
        end else if (accept) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (state_q == ST_IDLE) && (state_d == ST_IDLE) && !pend_q && !power_down_in;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************

    // Row command first, then the column command after the row-to-column gap
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (fall_tick && pend_q && !power_down_in) begin
                    state_d = ST_ROW;
                end
            end
            ST_ROW: begin
                if (fall_tick) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (fall_tick && wait_q == 4'h0) begin
                    state_d = ST_COL;
                end
            end
            ST_COL: begin
                if (fall_tick) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (fall_tick) begin
                    state_d = ST_IDLE;
                end
            end
            // Unused codes fall back to idle rather than lock up
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register; a pending request is held in pend_q while idle
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Gap counter; one memory clock is spent in the row state itself
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wait_q <= 4'h0;
        end else if (state_q == ST_ROW && fall_tick) begin
            wait_q <= ROW_TO_COL_MCLK - 4'h2;
        end else if (state_q == ST_WAIT && fall_tick && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
    end

    // Completion pulse as the sequencer returns to idle
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_DONE) && fall_tick;
        end
    end

    // ****************************************************************
    // Address multiplexer
    // ****************************************************************

    assign mux_bus.addr = addr_q;
    assign mux_bus.port_size = port_size_in;
    assign mux_bus.col_lines = col_lines_in;
    assign mux_bus.col_phase = (state_d == ST_COL);

    address_pin_mux u_addr_mux (
        .bus_if(mux_bus.mux)
    );

    // ****************************************************************
    // Pin registers, loaded on the falling memory edge
    // ****************************************************************

    // Address pins keep their value between commands to limit toggling
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pins_q <= ADDR_RESET;
        end else if (fall_tick && (state_d == ST_ROW || state_d == ST_COL)) begin
            pins_q <= mux_bus.pins;
        end
    end

    // Strobes are low for exactly one memory clock in their phase
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
        end else if (fall_tick) begin
            ras_n_q <= !(state_d == ST_ROW);
            cas_n_q <= !(state_d == ST_COL);
        end
    end

    // Write strobe low only in the column command of a write
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            we_n_q <= 1'b1;
        end else if (fall_tick) begin
            we_n_q <= !(state_d == ST_COL && write_q);
        end
    end

    // One select per block, low in the row and column commands and high in the wait between them
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cs_n_q <= BLOCK_NONE_N;
        end else if (fall_tick) begin
            cs_n_q <= BLOCK_NONE_N;
            if (state_d == ST_ROW || state_d == ST_COL) begin
                cs_n_q[block_q] <= 1'b0;
            end
        end
    end

    // Lane masks: enabled lanes unmasked in the column command, all masked otherwise
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            dqm_q <= LANES_MASKED;
        end else if (fall_tick) begin
            dqm_q <= (state_d == ST_COL) ? ~lane_en_q : LANES_MASKED;
        end
    end

    // Clock enable: command bit in command cycles when that mode is set,
    // otherwise low only while power-down is requested and nothing runs
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cke_q <= 1'b1;
        end else if (fall_tick) begin
            if (cke_command_mode_in && (state_d == ST_ROW || state_d == ST_COL)) begin
                cke_q <= cmd_bit_q;
            end else begin
                cke_q <= !(power_down_in && state_d == ST_IDLE);
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign req_ready_out = ready_q;
    assign done_out = done_q;
    assign addr_pins_out = pins_q;
    assign row_strobe_n_out = ras_n_q;
    assign col_strobe_n_out = cas_n_q;
    assign write_strobe_n_out = we_n_q;
    assign block_select_n_out = cs_n_q;
    assign mem_clock_enable_out = cke_q;
    assign byte_strobe_out = dqm_q;
    assign memory_clock_out = mem_clk_q;

endmodule : sdram_command_address_mux

// ==== hdl/sdram_pkg.sv ====
// Shared constants and types for the SDRAM command and address multiplexer
package sdram_pkg;

    // Port size as seen by the controller
    typedef enum logic [1:0] {
        PORT_8 = 2'h0,
        PORT_16 = 2'h1,
        PORT_32 = 2'h2
    } port_size_type;

    // Access sequencer states, Gray coded along idle-row-wait-column-done
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ROW = 3'h1,
        ST_WAIT = 3'h3,
        ST_COL = 3'h2,
        ST_DONE = 3'h6
    } seq_state_type;

    localparam int ADDR_W = 32;
    localparam int COL_LINES_W = 4;
    localparam int BLOCKS = 2;
    localparam int LANES = 2;

    // Pin positions of the multiplexed address map
    localparam int PIN_LOW = 9;
    localparam int PIN_BASE_TOP = 17;
    localparam int PIN_16_TOP = 16;
    localparam int PIN_32_TOP = 15;
    localparam int PIN_32_HI = 17;
    localparam int COL_32_HI = 16;
    localparam int PIN_EXTRA_LO = 18;
    localparam int PIN_ODD_LO = 19;
    localparam int PIN_8_EXTRA_HI = 25;
    localparam int PIN_16_EXTRA_HI = 26;
    localparam int LINES_MIN_8 = 10;
    localparam int LINES_MIN_WIDE = 9;
    localparam logic [COL_LINES_W-1:0] LINES_EIGHT = 4'h8;

    // Timing: system clock and forwarded memory clock
    localparam int SYS_CLK_NS = 20;
    localparam int MEM_CLK_NS = 160;
    localparam int HALF_CYCLES = (MEM_CLK_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYCLES - 1);
    // Memory clocks between row and column command
    localparam logic [3:0] ROW_TO_COL_MCLK = 4'h2;

    // Pin levels at reset; selects and masks return to them while idle
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [BLOCKS-1:0] BLOCK_NONE_N = 2'h3;
    localparam logic [LANES-1:0] LANES_MASKED = 2'h3;

endpackage : sdram_pkg

// ==== test/sdram_model.sv ====
// Behavioural SDRAM that latches row and column commands on the forwarded clock
`timescale 1ns/1ps
module sdram_model
    import sdram_pkg::*;
(
    input wire logic mem_clk_in,
    input wire logic [BLOCKS-1:0] select_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic cke_in,
    input wire logic [LANES-1:0] dqm_in,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [ADDR_W-1:0] row_out,
    output logic [ADDR_W-1:0] col_out,
    output logic write_out,
    output logic block_out,
    output logic [LANES-1:0] mask_out,
    output logic cke_out,
    output logic order_bad_out,
    output logic [7:0] commands_out
);
    logic open_q = 1'b0;
    initial order_bad_out = 1'b0;
    initial commands_out = 8'h00;
    // Every pin is taken in map order, as a board wired to all lines would see it
    // Clock enable is only recorded, since command mode reuses the pin as a command bit
    always @(posedge mem_clk_in) begin
        if (select_n_in != BLOCK_NONE_N) begin
            commands_out <= commands_out + 8'h01;
            block_out <= select_n_in[0];
            cke_out <= cke_in;
            if (!ras_n_in && cas_n_in) begin
                row_out <= addr_in;
                open_q <= 1'b1;
            end
            if (ras_n_in && !cas_n_in) begin
                col_out <= addr_in;
                write_out <= !we_n_in;
                mask_out <= dqm_in;
                order_bad_out <= order_bad_out | !open_q; // A column with no open row is an error
                open_q <= 1'b0;
            end
        end
    end
endmodule : sdram_model

// ==== test/sdram_mux_properties.sv ====
// Pin-level checks of the SDRAM command and address multiplexer
`timescale 1ns/1ps
module sdram_mux_properties
    import sdram_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_block_in,
    input wire logic [LANES-1:0] req_lane_en_in,
    input wire logic req_ready_out,
    input wire logic cke_command_mode_in,
    input wire logic cke_command_bit_in,
    input wire logic power_down_in,
    input wire logic [ADDR_W-1:0] addr_pins_out,
    input wire logic row_strobe_n_out,
    input wire logic col_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic [BLOCKS-1:0] block_select_n_out,
    input wire logic mem_clock_enable_out,
    input wire logic [LANES-1:0] byte_strobe_out,
    input wire logic memory_clock_out
);
    logic wr_q;
    logic blk_q;
    logic [LANES-1:0] lane_q;
    logic cmd_q;
    // Request fields kept from acceptance, so each pin can be tied to its cause
    always_ff @(posedge clk_sys_in) begin
        if (req_valid_in && req_ready_out && !power_down_in) begin
            wr_q <= req_write_in;
            blk_q <= req_block_in;
            lane_q <= req_lane_en_in;
            cmd_q <= cke_command_bit_in;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_row_one_period: assert property ($fell(row_strobe_n_out) |-> !row_strobe_n_out [*8] ##1 row_strobe_n_out)
        else $error("row strobe not low for one memory clock");
    a_row_cmd_alone: assert property (!row_strobe_n_out |-> col_strobe_n_out
        && block_select_n_out == (blk_q ? 2'h1 : 2'h2)) else $error("row command malformed");
    a_col_follows_row: assert property ($fell(row_strobe_n_out) |-> ##[9:24] $fell(col_strobe_n_out))
        else $error("column command missing after row");
    a_col_one_period: assert property ($fell(col_strobe_n_out) |-> !col_strobe_n_out [*8] ##1 col_strobe_n_out)
        else $error("column strobe not low for one memory clock");
    a_col_block_sel: assert property (!col_strobe_n_out |-> row_strobe_n_out
        && block_select_n_out == (blk_q ? 2'h1 : 2'h2)) else $error("column command malformed");
    a_write_level: assert property (!col_strobe_n_out |-> write_strobe_n_out == !wr_q)
        else $error("write strobe wrong for access");
    a_write_idle: assert property (col_strobe_n_out |-> write_strobe_n_out && byte_strobe_out == LANES_MASKED)
        else $error("write strobe or masks active outside column");
    a_dqm_lanes: assert property (!col_strobe_n_out |-> byte_strobe_out == ~lane_q)
        else $error("byte masks differ from lanes");
    a_block_idle: assert property (row_strobe_n_out && col_strobe_n_out |-> block_select_n_out == BLOCK_NONE_N)
        else $error("block selected outside command");
    a_cke_normal: assert property ((!power_down_in && !cke_command_mode_in) [*8] ##1
        (!power_down_in && !cke_command_mode_in) |-> mem_clock_enable_out) else $error("clock enable low while awake");
    a_cke_command: assert property (cke_command_mode_in && !(row_strobe_n_out && col_strobe_n_out)
        |-> mem_clock_enable_out == cmd_q) else $error("clock enable does not carry command bit");
    a_clock_period: assert property ($rose(memory_clock_out) |-> memory_clock_out [*4] ##1
        !memory_clock_out [*4] ##1 memory_clock_out) else $error("memory clock period wrong");
    a_pins_steady: assert property ($rose(memory_clock_out) |-> $stable(addr_pins_out))
        else $error("address pins move at memory clock rise");
    c_write: cover property ($fell(col_strobe_n_out) && !write_strobe_n_out);
    c_read: cover property ($fell(col_strobe_n_out) && write_strobe_n_out);
    c_sleep: cover property (power_down_in && !mem_clock_enable_out);
endmodule : sdram_mux_properties

bind sdram_command_address_mux sdram_mux_properties u_props (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_block_in(req_block_in),
    .req_lane_en_in(req_lane_en_in), .req_ready_out(req_ready_out), .cke_command_mode_in(cke_command_mode_in),
    .cke_command_bit_in(cke_command_bit_in), .power_down_in(power_down_in), .addr_pins_out(addr_pins_out),
    .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
    .write_strobe_n_out(write_strobe_n_out), .block_select_n_out(block_select_n_out),
    .mem_clock_enable_out(mem_clock_enable_out), .byte_strobe_out(byte_strobe_out),
    .memory_clock_out(memory_clock_out));

// ==== test/testbench.sv ====
// Self-checking bench of the SDRAM command and address multiplexer
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import sdram_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0;
    logic blk = 1'b0;
    logic [1:0] lane = 2'h3;
    port_size_type size = PORT_8;
    logic [3:0] lines = 4'h8;
    logic cmode = 1'b0;
    logic cbit = 1'b0;
    logic pd = 1'b0;
    logic ready, done, ras_n, cas_n, we_n, cke, mclk, m_wr, m_blk, m_cke, m_bad;
    logic [31:0] pins, m_row, m_col;
    logic [1:0] sel_n, dqm, m_mask;
    logic [7:0] m_cmds;
    int errors = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    sdram_command_address_mux dut (.clk_sys_in(clk), .sys_rst_in(rst), .req_valid_in(valid),
        .req_write_in(wr), .req_addr_in(addr), .req_block_in(blk), .req_lane_en_in(lane),
        .req_ready_out(ready), .done_out(done), .port_size_in(size), .col_lines_in(lines),
        .cke_command_mode_in(cmode), .cke_command_bit_in(cbit), .power_down_in(pd), .addr_pins_out(pins),
        .row_strobe_n_out(ras_n), .col_strobe_n_out(cas_n), .write_strobe_n_out(we_n),
        .block_select_n_out(sel_n), .mem_clock_enable_out(cke), .byte_strobe_out(dqm),
        .memory_clock_out(mclk));
    sdram_model mem (.mem_clk_in(mclk), .select_n_in(sel_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
        .we_n_in(we_n), .cke_in(cke), .dqm_in(dqm), .addr_in(pins), .row_out(m_row), .col_out(m_col),
        .write_out(m_wr), .block_out(m_blk), .mask_out(m_mask), .cke_out(m_cke), .order_bad_out(m_bad),
        .commands_out(m_cmds));
    // ****************************************
    // Expected column map
    // ****************************************
    function automatic logic [31:0] col_exp(input logic [31:0] a, input port_size_type s, input logic [3:0] n);
        logic [31:0] e;
        e = a; // Pins outside the column map keep their row bit
        if (s == PORT_8) begin
            for (int p = 9; p <= 17; p++) e[p] = a[17-p];
            for (int p = 19; p <= 25; p += 2) if (n >= 4'(p / 2 + 1)) e[p] = a[p-1];
        end else if (s == PORT_16) begin
            for (int p = 9; p <= 16; p++) e[p] = a[17-p];
            for (int p = 18; p <= 26; p++) if (n >= 4'(9 + (p - 18) / 2)) e[p] = a[p-1];
        end else begin
            for (int p = 9; p <= 15; p++) e[p] = a[17-p];
            e[17] = a[16];
            if (n == 4'h8) e[18] = a[17];
            for (int p = 19; p <= 25; p += 2) if (n >= 4'(p / 2)) e[p] = a[p-1];
        end
        return e;
    endfunction : col_exp
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic finish_test;
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // One whole access; waits are bounded so a stuck sequencer shows up as a mismatch
    task automatic access(input logic w, input logic [31:0] a, input logic b, input logic [1:0] l);
        int k;
        k = 0;
        do begin @(negedge clk); k++; end while (ready !== 1'b1 && k < 100);
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        addr <= a;
        blk <= b;
        lane <= l;
        @(posedge clk);
        valid <= 1'b0;
        do begin @(negedge clk); k++; end while (done !== 1'b1 && k < 200);
        `CHECK(done, 1'b1)
        `CHECK(m_bad, 1'b0)
    endtask : access
    task automatic reset_levels;
        `CHECK({ras_n, cas_n, we_n, sel_n, cke, dqm}, 8'hff)
    endtask : reset_levels
    task automatic map_sweep;
        logic [31:0] a;
        for (int s = 0; s < 4; s++) for (int n = 8; n <= 13; n++) begin
            a = n[0] ? 32'h5a3c_96e1 : 32'ha5c3_691e;
            @(posedge clk);
            size <= port_size_type'(s);
            lines <= 4'(n);
            access(1'b0, a, 1'b0, 2'h3);
            `CHECK(m_row, a)
            `CHECK(m_col, col_exp(a, port_size_type'(s), 4'(n)))
        end
    endtask : map_sweep
    task automatic write_read;
        access(1'b1, 32'h0012_3456, 1'b1, 2'h1);
        `CHECK({m_wr, m_blk, m_mask}, 4'he)
        access(1'b0, 32'h00ab_cdef, 1'b0, 2'h2);
        `CHECK({m_wr, m_blk, m_mask}, 4'h1)
    endtask : write_read
    task automatic sleep_refuse;
        logic [7:0] c;
        c = m_cmds;
        @(posedge clk);
        pd <= 1'b1;
        valid <= 1'b1;
        repeat (40) @(posedge clk);
        `CHECK(cke, 1'b0)
        `CHECK(m_cmds, c)
        pd <= 1'b0;
        valid <= 1'b0;
    endtask : sleep_refuse
    task automatic command_bit;
        @(posedge clk);
        cmode <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            cbit <= b[0];
            access(1'b1, 32'h0f0f_0f0f, 1'b0, 2'h3);
            `CHECK(m_cke, b[0])
        end
        @(posedge clk);
        cmode <= 1'b0;
    endtask : command_bit
    task automatic clock_rate;
        int r[$];
        logic p;
        p = mclk;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (mclk === 1'b1 && p === 1'b0) r.push_back(i);
            p = mclk;
        end
        `CHECK(r[1] - r[0], 8)
    endtask : clock_rate
    // Main sequence with a watchdog well beyond the expected run of some 1200 cycles
    initial begin
        repeat (10) @(posedge clk);
        reset_levels();
        rst <= 1'b0;
        clock_rate();
        map_sweep();
        write_read();
        sleep_refuse();
        command_bit();
        finish_test();
    end
    initial begin
        repeat (6000) @(posedge clk);
        $display("mismatch at %0t: watchdog expired", $time);
        errors++;
        finish_test();
    end
endmodule : testbench
